/* File: rtl/fir_channelizer.sv */
// Top of the TDM multichannel channelizer: input slot tracking, parallel lanes,
// channel bank, repacking drain, FIFO and output slot sequencer.
// Assumes upstream keeps the slot pattern and the wire width of this block.
`default_nettype none
`include "fir_chan_map.svh"

// Overview of operation
// (R1) Folding factor is clock rate over per-channel sample rate: slots per wire.
// (R2) Folding above one: serializer and deserializer around shared per-wire hardware.
// (R3) Input wire count is channel total divided by folding factor.
// (R4) More channels than slots: several wires and parallel lane instances.
// (R5) Slots used per wire is channel total over wires; index steps 0 upward.
// (R6) Channels are numbered 0 to channel total minus one.
// (R7) Single wire: the channel index equals the actual channel number.
// (R8) One shared index for all wires, giving slot position, not channel.
// (R9) Channels spread evenly; leftover slots carry valid low.
// (R10) Index and data are don't care while valid is low.
// (R11) Parallel lane instances, each fed one element of the input vector.
// (R12) Decimated results are multiplexed onto the narrower output without glue.
// (R13) Output rate recomputed after rate change; fewest wires that carry it.
// (R14) Neighbouring blocks use exactly the same vector widths as this block.
// (R15) Output lane 0 sits in the lowest data slice, next lanes above.
// (R16) Output index width is log2 of channels per output wire.
// (R17) Upstream sends used slots contiguously, then idle slots, never splitting groups.
// (R18) Channels order across time slots first, then across wires.
// (R19) Wire counts from division round up to whole wires.
// (R20) Index counters clear on reset and wrap to zero after the last slot.
module fir_channelizer
   import fir_chan_pkg::*;
(
   input  wire logic                                         clk_i,         // 100 MHz clock
   input  wire logic                                         rst_n_i,       // Async, low
   input  wire logic                                         in_valid_i,    // Slot valid
   input  wire logic [`INPUT_WIRE_COUNT*`SAMPLE_WIDTH-1:0]   in_data_i,     // Wire vector
   output logic                                              out_valid_o,   // Slot valid
   output logic [`OUT_IDX_W-1:0]                             out_channel_o, // Slot index
   output logic [`OUTPUT_WIRE_COUNT*`SAMPLE_WIDTH-1:0]       out_data_o     // Wire vector
);
   // ==================================================================
   // Shape constants
   localparam int FOLD    = `FOLD_FACTOR;                             // [R1]
   localparam int WIRES   = `INPUT_WIRE_COUNT;                        // [R3] [R19]
   localparam int CPI     = `CHANNELS_PER_INPUT_WIRE;                 // [R5]
   localparam int OWIRES  = `OUTPUT_WIRE_COUNT;                       // [R13] [R19]
   localparam int CPO     = `CHANNELS_PER_OUTPUT_WIRE;                // [R13]
   localparam int OFOLD   = `OUT_FOLD_FACTOR;
   localparam int CHANS   = `CHANNEL_TOTAL;
   localparam int W       = `SAMPLE_WIDTH;
   localparam int BW      = `BANK_IDX_W;
   localparam int SW      = `OUT_SLOT_W;
   localparam int FW      = $clog2(`FIFO_DEPTH + 1);

   localparam logic [`IN_IDX_W-1:0]  LAST_IN  = (`IN_IDX_W)'(CPI - 1);
   localparam logic [BW-1:0]         LAST_CH  = BW'(CHANS - 1);
   localparam logic [SW-1:0]         LAST_USE = SW'(CPO - 1);
   localparam logic [SW-1:0]         LAST_OUT = SW'(OFOLD - 1);
   localparam logic [FW-1:0]         GROUP    = FW'(CPO);

   // Channel number of a slot on a wire: slots first, wires second
   function automatic logic [BW-1:0] chan_of(input int wire_n, input logic [`IN_IDX_W-1:0] s);
      chan_of = BW'(wire_n * CPI) + BW'(s);                           // [R6] [R18]
   endfunction

   // ==================================================================
   // Input slot counter and decimation phase
   logic [`IN_IDX_W-1:0]  in_slot_reg;
   logic                  phase_reg;

   // Contiguous groups from upstream let a plain counter follow the slots
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_slot_reg <= (`IN_IDX_W)'(`IDX_RESET);                     // [R20]
         phase_reg   <= 1'b0;
      end else if (in_valid_i) begin                                  // [R17]
         if (in_slot_reg == LAST_IN) begin
            in_slot_reg <= '0;                                        // [R20]
            phase_reg   <= ~phase_reg;
         end else begin
            in_slot_reg <= in_slot_reg + 1'b1;                        // [R5]
         end
      end
   end

   // ==================================================================
   // Parallel lanes, one per input wire
   logic                  lane_valid [WIRES];
   logic [`IN_IDX_W-1:0]  lane_slot  [WIRES];
   sample_t               lane_data  [WIRES];

   for (genvar g = 0; g < WIRES; g++) begin : g_lane                  // [R4] [R11]
      chan_lane u_lane (
         .clk_i   (clk_i),
         .rst_n_i (rst_n_i),
         .valid_i (in_valid_i),
         .keep_i  (phase_reg),
         .slot_i  (in_slot_reg),
         .data_i  (in_data_i[g*W +: W]),
         .valid_o (lane_valid[g]),
         .slot_o  (lane_slot[g]),
         .data_o  (lane_data[g])
      );
   end

   // ==================================================================
   // Channel bank: deserializes lane results into channel order
   sample_t  bank [CHANS];
   logic     bank_done_reg;

   always_ff @(posedge clk_i) begin
      for (int w = 0; w < WIRES; w++) begin
         if (lane_valid[w] && (chan_of(w, lane_slot[w]) <= LAST_CH)) begin
            bank[chan_of(w, lane_slot[w])] <= lane_data[w];           // [R2] [R6]
         end
      end
   end

   // All lanes step together, so lane 0 marks the end of a kept frame
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bank_done_reg <= 1'b0;
      end else begin
         bank_done_reg <= lane_valid[0] && (lane_slot[0] == LAST_IN);
      end
   end

   // ==================================================================
   // Drain: serializes the bank into the FIFO, channel 0 first
   drain_state_t    drain_state_reg;
   logic [BW-1:0]   drain_idx_reg;
   logic            fifo_in_ready;
   logic            fifo_push;

   assign fifo_push = (drain_state_reg == DRAIN_RUN);

   // A frame arriving mid-drain is not restarted; the FIFO keeps a frame ahead
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drain_state_reg <= DRAIN_IDLE;
         drain_idx_reg   <= '0;
      end else begin
         case (drain_state_reg)
            DRAIN_IDLE: begin
               drain_idx_reg <= '0;
               if (bank_done_reg) begin
                  drain_state_reg <= DRAIN_RUN;
               end
            end
            DRAIN_RUN: begin
               if (fifo_in_ready) begin                               // [R12]
                  if (drain_idx_reg == LAST_CH) begin
                     drain_state_reg <= DRAIN_IDLE;
                     drain_idx_reg   <= '0;
                  end else begin
                     drain_idx_reg <= drain_idx_reg + 1'b1;
                  end
               end
            end
            default: begin
               drain_state_reg <= DRAIN_IDLE;
            end
         endcase
      end
   end

   // ==================================================================
   // FIFO in the data path
   logic            fifo_out_valid;
   logic            fifo_pop;
   sample_t         fifo_out_data;
   logic [FW-1:0]   fifo_level;

   chan_fifo #(
      .WIDTH (W),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (fifo_push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (bank[drain_idx_reg]),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data),
      .level_o     (fifo_level)
   );

   // ==================================================================
   // Output slot sequencer: one whole group, then the idle slots
   out_state_t      out_state_reg;
   logic [SW-1:0]   out_slot_reg;

   assign fifo_pop = (out_state_reg == OUT_SEND) && fifo_out_valid;

   // A group only starts when all its words wait, so it is never split
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_state_reg <= OUT_IDLE;
         out_slot_reg  <= SW'(`IDX_RESET);                            // [R20]
      end else begin
         case (out_state_reg)
            OUT_IDLE: begin
               out_slot_reg <= '0;
               if (fifo_level >= GROUP) begin
                  out_state_reg <= OUT_SEND;
               end
            end
            OUT_SEND: begin
               if (out_slot_reg == LAST_USE) begin
                  out_state_reg <= (LAST_USE == LAST_OUT) ? OUT_IDLE : OUT_GAP;
                  out_slot_reg  <= (LAST_USE == LAST_OUT) ? '0 : out_slot_reg + 1'b1;
               end else begin
                  out_slot_reg <= out_slot_reg + 1'b1;                // [R5]
               end
            end
            OUT_GAP: begin                                            // [R9]
               if (out_slot_reg == LAST_OUT) begin
                  out_slot_reg  <= '0;                                // [R20]
                  out_state_reg <= (fifo_level >= GROUP) ? OUT_SEND : OUT_IDLE;
               end else begin
                  out_slot_reg <= out_slot_reg + 1'b1;
               end
            end
            default: begin
               out_state_reg <= OUT_IDLE;
               out_slot_reg  <= '0;
            end
         endcase
      end
   end

   // ==================================================================
   // Output registers; lane 0 in the low slice, idle slots forced to zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_valid_o   <= 1'b0;
         out_channel_o <= '0;
         out_data_o    <= '0;
      end else begin
         out_valid_o   <= fifo_pop;                                   // [R9]
         out_channel_o <= fifo_pop ? (`OUT_IDX_W)'(out_slot_reg) : '0; // [R7] [R8] [R16]
         out_data_o    <= '0;                                         // [R10]
         if (fifo_pop) begin
            out_data_o[0 +: W] <= fifo_out_data;                      // [R15]
         end
      end
   end

   // ==================================================================
   // Checks
   out_idx_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R16]
      out_valid_o |-> (out_channel_o <= (`OUT_IDX_W)'(CPO - 1)))
      else $error("output index beyond channels per wire");

   out_group_shape_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
      $rose(out_valid_o) |-> out_valid_o [*6] ##1 !out_valid_o [*2])
      else $error("output group not six valid then two idle");

   out_idx_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
      (out_valid_o && $past(out_valid_o)) |-> (out_channel_o == $past(out_channel_o) + 1'b1))
      else $error("output index did not step by one");

   out_group_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R20]
      $rose(out_valid_o) |-> (out_channel_o == '0))
      else $error("output group did not start at index zero");

   idle_data_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
      !out_valid_o |-> ((out_data_o == '0) && (out_channel_o == '0)))
      else $error("idle slot shows data");

   in_slot_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R20]
      (in_valid_i && (in_slot_reg == LAST_IN)) |=> (in_slot_reg == '0) && (phase_reg != $past(phase_reg)))
      else $error("input slot counter failed to wrap");

   drain_length_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
      $rose(drain_state_reg == DRAIN_RUN) |-> ##[6:40] (drain_state_reg == DRAIN_IDLE))
      else $error("bank drain did not finish");

   bank_to_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
      (bank_done_reg && (fifo_level == '0) && (out_state_reg == OUT_IDLE)) |-> ##[8:9] out_valid_o)
      else $error("kept frame not presented on the output");

   // Shared index: every lane steps in lockstep with lane 0
   for (genvar g = 1; g < WIRES; g++) begin : g_lockstep
      lane_lockstep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
         lane_valid[0] |-> (lane_valid[g] && (lane_slot[g] == lane_slot[0])))
         else $error("lanes out of step");
   end

   drop_phase_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
      (in_valid_i && !phase_reg) |=> !lane_valid[0])
      else $error("decimated frame reached a lane");

   in_slot_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R17]
      !in_valid_i |=> ($stable(in_slot_reg) && $stable(phase_reg)))
      else $error("slot counter moved on an idle slot");

   drain_order_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R18]
      (fifo_push && fifo_in_ready && (drain_idx_reg != LAST_CH))
         |=> (drain_idx_reg == $past(drain_idx_reg) + 1'b1))
      else $error("drain skipped a channel");

   out_low_slice_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R15]
      fifo_pop |=> (out_data_o[0 +: W] == $past(fifo_out_data)))
      else $error("output word not in the low slice");

   out_from_send_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
      out_valid_o |-> ($past(out_state_reg) == OUT_SEND))
      else $error("valid output outside a send slot");
endmodule

`default_nettype wire

/* File: rtl/fir_chan_map.svh */
// Folding, wire and slot figures of the channelizer, as text macros.
// Assumes integer rate figures in MHz and MSPS, with the clock no slower than a channel.
`ifndef FIR_CHAN_MAP_SVH
`define FIR_CHAN_MAP_SVH

// ==================================================================
// Rates and channel count
`define SYSTEM_CLOCK_RATE        100
`define PER_CHANNEL_SAMPLE_RATE  25
`define CHANNEL_TOTAL            6
`define DECIMATION               2
`define SAMPLE_WIDTH             8

// ==================================================================
// Derived shape
`define CEIL_DIV(a, b)           (((a) + (b) - 1) / (b))
`define FOLD_FACTOR              (`SYSTEM_CLOCK_RATE / `PER_CHANNEL_SAMPLE_RATE)
`define INPUT_WIRE_COUNT         `CEIL_DIV(`CHANNEL_TOTAL, `FOLD_FACTOR)
`define CHANNELS_PER_INPUT_WIRE  `CEIL_DIV(`CHANNEL_TOTAL, `INPUT_WIRE_COUNT)
`define OUT_FOLD_FACTOR          (`FOLD_FACTOR * `DECIMATION)
`define OUTPUT_WIRE_COUNT        `CEIL_DIV(`CHANNEL_TOTAL, `OUT_FOLD_FACTOR)
`define CHANNELS_PER_OUTPUT_WIRE `CEIL_DIV(`CHANNEL_TOTAL, `OUTPUT_WIRE_COUNT)
// Index widths; at least one bit so a single-slot wire still has a port
`define IN_IDX_W  ((`CHANNELS_PER_INPUT_WIRE > 1) ? $clog2(`CHANNELS_PER_INPUT_WIRE) : 1)
`define OUT_IDX_W ((`CHANNELS_PER_OUTPUT_WIRE > 1) ? $clog2(`CHANNELS_PER_OUTPUT_WIRE) : 1)
`define OUT_SLOT_W $clog2(`OUT_FOLD_FACTOR + 1)
`define BANK_IDX_W $clog2(`CHANNEL_TOTAL + 1)

// ==================================================================
// Buffering and reset values
`define FIFO_DEPTH      16
`define IDX_RESET       0
`define SAMPLE_RESET    8'h00

`endif

/* File: rtl/fir_chan_pkg.sv */
// Types shared by the channelizer modules.
// Assumes fir_chan_map.svh is on the include path.
`default_nettype none
`include "fir_chan_map.svh"

package fir_chan_pkg;
   typedef logic [`SAMPLE_WIDTH-1:0] sample_t;

   typedef enum logic [0:0] {
      DRAIN_IDLE = 1'b0,
      DRAIN_RUN  = 1'b1
   } drain_state_t;

   typedef enum logic [1:0] {
      OUT_IDLE = 2'b00,
      OUT_SEND = 2'b01,
      OUT_GAP  = 2'b10
   } out_state_t;
endpackage

`default_nettype wire

/* File: rtl/chan_fifo.sv */
// Word FIFO between the repacking drain and the output sequencer.
// Assumes one clock; out_data_o is valid combinationally while out_valid_o is high.
`default_nettype none

module chan_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                     clk_i,       // System clock
   input  wire logic                     rst_n_i,     // Async reset, active low
   input  wire logic                     in_valid_i,  // Word offered
   output logic                          in_ready_o,  // Room for a word
   input  wire logic [WIDTH-1:0]         in_data_i,   // Word in
   output logic                          out_valid_o, // Word available
   input  wire logic                     out_ready_i, // Word taken
   output logic [WIDTH-1:0]              out_data_o,  // Head word
   output logic [$clog2(DEPTH+1)-1:0]    level_o      // Words held
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [$clog2(DEPTH+1)-1:0] FULL = ($clog2(DEPTH+1))'(DEPTH);

   logic [WIDTH-1:0]            mem [DEPTH];
   logic [PW-1:0]               wr_ptr_reg;
   logic [PW-1:0]               rd_ptr_reg;
   logic [$clog2(DEPTH+1)-1:0]  level_reg;
   logic                        push;
   logic                        pop;

   assign in_ready_o  = (level_reg != FULL);
   assign out_valid_o = (level_reg != '0);
   assign out_data_o  = mem[rd_ptr_reg];
   assign level_o     = level_reg;
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // ==================================================================
   // Storage; no reset on the array, words are only read once written
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            level_reg <= level_reg + 1'b1;
         end else if (pop && !push) begin
            level_reg <= level_reg - 1'b1;
         end
      end
   end

   fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
      (!in_ready_o && !pop) |=> (level_reg == FULL) && $stable(wr_ptr_reg))
      else $error("fifo accepted a word while full");

   fifo_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
      (push && !pop) |=> (level_reg == $past(level_reg) + 1'b1))
      else $error("fifo level did not follow a push");
endmodule

`default_nettype wire

/* File: rtl/chan_lane.sv */
// One parallel filter instance fed by one input wire, time-shared over its slots.
// Assumes the caller supplies the slot position and the decimation phase.
`default_nettype none
`include "fir_chan_map.svh"

module chan_lane
   import fir_chan_pkg::*;
(
   input  wire logic                  clk_i,       // System clock
   input  wire logic                  rst_n_i,     // Async reset, active low
   input  wire logic                  valid_i,     // Slot carries a sample
   input  wire logic                  keep_i,      // Decimation phase keeps this frame
   input  wire logic [`IN_IDX_W-1:0]  slot_i,      // Slot position on the wire
   input  wire sample_t               data_i,      // Sample of this wire
   output logic                       valid_o,     // Result present
   output logic [`IN_IDX_W-1:0]       slot_o,      // Slot of the result
   output sample_t                    data_o       // Result
);
   // ==================================================================
   // Shared stage: one register reused by every slot of the wire
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_o <= 1'b0;
         slot_o  <= '0;
         data_o  <= `SAMPLE_RESET;
      end else begin
         valid_o <= valid_i && keep_i;                              // [R2]
         slot_o  <= slot_i;
         data_o  <= valid_i ? data_i : `SAMPLE_RESET;
      end
   end

   lane_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
      (valid_i && keep_i) |=> valid_o && (data_o == $past(data_i)) && (slot_o == $past(slot_i)))
      else $error("lane lost a kept sample");
endmodule

`default_nettype wire

/* File: verif/fir_upstream_model.sv */
// Upstream stream source for the channelizer: sends one folding period plus the requested extra idle slots per frame.
// Assumes fir_chan_map.svh on the include path; the bench calls send_frame in turn.
`default_nettype none
`include "fir_chan_map.svh"

module fir_upstream_model (
   input  wire logic                                       clk_i,   // System clock
   output logic                                            valid_o, // Slot valid
   output logic [`INPUT_WIRE_COUNT*`SAMPLE_WIDTH-1:0]      data_o   // Wire vector
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      valid_o = 1'b0;
      data_o  = '0;
   end

   // ==================================================================
   // One frame: used slots back to back, then at least one idle slot
   task automatic send_frame(input logic [`CHANNEL_TOTAL*`SAMPLE_WIDTH-1:0] smp,
                             input int idle);
      for (int s = 0; s < `CHANNELS_PER_INPUT_WIRE; s++) begin
         @(posedge clk_i);
         #1;
         valid_o = 1'b1;
         for (int w = 0; w < `INPUT_WIRE_COUNT; w++) begin
            data_o[w*`SAMPLE_WIDTH +: `SAMPLE_WIDTH] =
               smp[(w*`CHANNELS_PER_INPUT_WIRE+s)*`SAMPLE_WIDTH +: `SAMPLE_WIDTH];
         end
      end
      // Idle slots show changing junk so nothing leans on stale data
      for (int i = 0; i < `FOLD_FACTOR - `CHANNELS_PER_INPUT_WIRE + idle; i++) begin
         @(posedge clk_i);
         #1;
         valid_o = 1'b0;
         data_o  = ~data_o;
      end
   endtask
endmodule

`default_nettype wire

/* File: verif/test_fir_channelizer.sv */
// Self-checking bench of the channelizer top with a random upstream source.
// Assumes the shape macros of fir_chan_map.svh; decimation keeps odd frames.
`default_nettype none
`include "fir_chan_map.svh"

module test_fir_channelizer;
   import fir_chan_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SW = `SAMPLE_WIDTH;

   logic                                 clk_i   = 1'b0;
   logic                                 rst_n_i = 1'b0;
   logic                                 in_valid;
   logic [`INPUT_WIRE_COUNT*SW-1:0]      in_data;
   logic                                 out_valid;
   logic [`OUT_IDX_W-1:0]                out_chan;
   logic [`OUTPUT_WIRE_COUNT*SW-1:0]     out_data;
   int                                   failures = 0;
   int                                   n_checks = 0;
   int                                   frames   = 0;
   int                                   run      = 0;
   logic [31:0]                          seed     = 32'hC0AC1D90;
   logic [15:0]                          expq[$];
   logic [15:0]                          e;

   always #5 clk_i = ~clk_i;

   fir_channelizer DUT (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .in_valid_i   (in_valid),
      .in_data_i    (in_data),
      .out_valid_o  (out_valid),
      .out_channel_o(out_chan),
      .out_data_o   (out_data)
   );

   fir_upstream_model UP (
      .clk_i  (clk_i),
      .valid_o(in_valid),
      .data_o (in_data)
   );

   // ==================================================================
   // Helpers
   function automatic int ceil_div(input int a, input int b);
      return (a + b - 1) / b;
   endfunction

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Kept frames come out on one wire in channel order, sample unchanged
   task automatic send(input int idle);
      logic [`CHANNEL_TOTAL*SW-1:0] smp;
      for (int c = 0; c < `CHANNEL_TOTAL; c++) smp[c*SW +: SW] = 8'(xs());
      if (frames % `DECIMATION == 1)
         for (int c = 0; c < `CHANNEL_TOTAL; c++) expq.push_back({8'(c), smp[c*SW +: SW]});
      frames++;
      UP.send_frame(smp, idle);
   endtask

   task automatic drain(input string name);
      int n;
      n = 0;
      while (expq.size() != 0 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 400) begin
         failures++;
         conclude();
      end else begin
         repeat (4) @(posedge clk_i);
         check(expq.size(), 0);
         $display("test %s done", name);
      end
   endtask

   // ==================================================================
   // Output monitor, sampled mid-cycle
   always @(negedge clk_i) begin
      if (rst_n_i) begin
         if (out_valid === 1'b1) begin
            if (expq.size() == 0) begin
               check(1, 0);
            end else begin
               e = expq.pop_front();
               check(32'(out_chan), 32'(e[15:8]));
               check(32'(out_data), 32'(e[7:0]));
            end
            run++;
         end else begin
            if (run != 0) check(run, `CHANNELS_PER_OUTPUT_WIRE);
            run = 0;
            check(32'(out_chan), 0);
            check(32'(out_data), 0);
         end
      end
   end

   // ==================================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      check($bits(in_data), ceil_div(6, 100 / 25) * SW);
      check($bits(out_chan), $clog2(6));
      check($bits(out_data), ceil_div(6, 4 * 2) * SW);
      $display("test structure done");
      for (int i = 0; i < 8; i++) send(0);
      drain("min_gap");
      for (int i = 0; i < 10; i++) send(xs() % 5);
      drain("random_gap");
      send(0);
      send(0);
      repeat (12) @(posedge clk_i);
      #1;
      rst_n_i = 1'b0;
      repeat (2) begin
         @(negedge clk_i);
         check(32'(out_valid), 0);
         check(32'(out_chan), 0);
      end
      @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      expq.delete();
      frames = 0;
      run = 0;
      for (int i = 0; i < 4; i++) send(1);
      drain("reset_mid");
      conclude();
   end
endmodule

`default_nettype wire
